// file: rhbp_core.sv
// Receive channel provisioning word two, block pointer RAM and their indirect access logic
//
// Summary of operation
// - Request transfer at fill threshold or held end-of-packet
// - Threshold and transfer are 16*(size+1) bytes
// - Output offset-field count of invalid bytes with each serial bit
// - Invert channel serial stream when inversion bit set
// - Precedence channels serviced before all other channels
// - Seven-bit mode drops last bit of each octet
// - Data fields hold written value until channel read
// - Block select write starts indirect block pointer access
// - Direction zero stores pointer, one fetches entry
// - Block busy high from select write until done
// - Entries hold next block, forming circular chains
// - Pointer field holds written value until block read
// - Channel select write starts channel RAM access
`timescale 1ns/10ps
module rhbp_core
    import rhbp_pkg::*;
(
    input  wire logic                               clk_i,
    input  wire logic                               rst_i,
    input  wire rhbp_req_t                          req_i,
    output logic [31:0]                             rdata_o,
    input  wire logic [NUM_CHAN-1:0][FILL_W-1:0]    chan_fill_i,
    input  wire logic [NUM_CHAN-1:0]                chan_eop_i,
    output logic [NUM_CHAN-1:0]                     xfer_req_o,
    output logic                                    svc_valid_o,
    output logic [CHAN_W-1:0]                       svc_chan_o,
    output logic [THR_W-1:0]                        svc_bytes_o,
    input  wire logic                               rx_valid_i,
    input  wire logic [CHAN_W-1:0]                  rx_chan_i,
    input  wire logic                               rx_bit_i,
    input  wire logic [2:0]                         rx_bit_pos_i,
    output logic                                    rx_valid_o,
    output logic                                    rx_bit_o,
    output logic [OFS_W-1:0]                        rx_offset_o,
    input  wire logic [BLK_W-1:0]                   walk_blk_i,
    output logic [BLK_W-1:0]                        walk_next_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode
    wire access   = (req_i.wr | req_i.rd) & (|req_i.be);
    wire wr_en    = access & req_i.wr;
    wire rd_en    = access & req_i.rd;
    wire hit_chs  = req_i.addr == OFF_CH_SEL;
    wire hit_ch2  = req_i.addr == OFF_CH_DATA2;
    wire hit_bls  = req_i.addr == OFF_BLK_SEL;
    wire hit_bld  = req_i.addr == OFF_BLK_DATA;

    rhbp_acc_state_t    ch_state_q;
    rhbp_acc_state_t    blk_state_q;
    logic [1:0]         ch_cnt_q;
    logic [1:0]         blk_cnt_q;
    logic [CHAN_W-1:0]  ch_num_q;
    logic               ch_dir_q;
    logic [BLK_W-1:0]   blk_num_q;
    logic               blk_dir_q;
    rhbp_prov2_t        data2_q;
    logic [BLK_W-1:0]   bptr_q;
    rhbp_prov2_t        prov_ram_q [NUM_CHAN];
    logic [BLK_W-1:0]   blk_ram_q  [NUM_BLK];
    logic [31:0]        rdata_q;

    wire ch_busy   = ch_state_q == ACC_BUSY;
    wire blk_busy  = blk_state_q == ACC_BUSY;
    // Select writes during an access are dropped so the access in flight stays intact
    wire ch_start  = wr_en & hit_chs & ~ch_busy;
    wire blk_start = wr_en & hit_bls & ~blk_busy;
    wire ch_done   = ch_busy & (ch_cnt_q == 2'h0);
    wire blk_done  = blk_busy & (blk_cnt_q == 2'h0);

    wire rhbp_prov2_t     ch_ram_rd  = prov_ram_q[ch_num_q];
    wire logic [BLK_W-1:0] blk_ram_rd = blk_ram_q[blk_num_q];

    ////////////////////////////////////////////////////////////////////////////////
    // Channel access sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch_state_q <= ACC_IDLE;
            ch_cnt_q   <= 2'h0;
        end else begin
            case (ch_state_q)
                ACC_IDLE: begin
                    if (ch_start) begin
                        ch_state_q <= ACC_BUSY;
                        ch_cnt_q   <= ACC_LAT - 2'h1;
                    end
                end
                ACC_BUSY: begin
                    if (ch_done) begin
                        ch_state_q <= ACC_IDLE;
                    end else begin
                        ch_cnt_q <= ch_cnt_q - 2'h1;
                    end
                end
                default: ch_state_q <= ACC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch_num_q <= '0;
            ch_dir_q <= 1'b0;
        end else if (ch_start) begin
            ch_num_q <= req_i.wdata[CHAN_W-1:0];
            ch_dir_q <= req_i.wdata[DIR_BIT];
        end
    end

    // Completed read beats a same-cycle host write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data2_q <= PROV2_RST;
        end else if (ch_done & ch_dir_q) begin
            data2_q <= ch_ram_rd;
        end else if (wr_en & hit_ch2) begin
            data2_q <= {req_i.wdata[SEVEN_BIT], req_i.wdata[PRIO_BIT], req_i.wdata[INV_BIT],
                        req_i.wdata[OFS_LSB +: OFS_W], req_i.wdata[XFER_LSB +: XFER_W]};
        end
    end

    // Reset so per-channel outputs are defined before provisioning
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                prov_ram_q[i] <= PROV2_RST;
            end
        end else if (ch_done & ~ch_dir_q) begin
            prov_ram_q[ch_num_q] <= data2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Block access sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blk_state_q <= ACC_IDLE;
            blk_cnt_q   <= 2'h0;
        end else begin
            case (blk_state_q)
                ACC_IDLE: begin
                    if (blk_start) begin
                        blk_state_q <= ACC_BUSY;
                        blk_cnt_q   <= ACC_LAT - 2'h1;
                    end
                end
                ACC_BUSY: begin
                    if (blk_done) begin
                        blk_state_q <= ACC_IDLE;
                    end else begin
                        blk_cnt_q <= blk_cnt_q - 2'h1;
                    end
                end
                default: blk_state_q <= ACC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blk_num_q <= '0;
            blk_dir_q <= 1'b0;
        end else if (blk_start) begin
            blk_num_q <= req_i.wdata[BLK_W-1:0];
            blk_dir_q <= req_i.wdata[DIR_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bptr_q <= '0;
        end else if (blk_done & blk_dir_q) begin
            bptr_q <= blk_ram_rd;
        end else if (wr_en & hit_bld) begin
            bptr_q <= req_i.wdata[BLK_W-1:0];
        end
    end

    // Large array left unreset; software initialises every link
    always_ff @(posedge clk_i) begin
        if (blk_done & ~blk_dir_q) begin
            blk_ram_q[blk_num_q] <= bptr_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read-back
    wire [31:0] rd_chs = {16'h0, ch_busy, ch_dir_q, 9'h0, ch_num_q};
    wire [31:0] rd_ch2 = {16'h0, data2_q.seven_bit_mode, data2_q.prio_en, data2_q.invert,
                          3'h0, data2_q.offset, 5'h0, data2_q.transfer_size};
    wire [31:0] rd_bls = {16'h0, blk_busy, blk_dir_q, 5'h0, blk_num_q};
    wire [31:0] rd_bld = {23'h0, bptr_q};
    wire [31:0] rdata_d = hit_chs ? rd_chs :
                          hit_ch2 ? rd_ch2 :
                          hit_bls ? rd_bls :
                          hit_bld ? rd_bld : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0;
        end else if (rd_en) begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Transfer requests and service order
    logic [NUM_CHAN-1:0]            req_hi;
    logic [NUM_CHAN-1:0]            req_lo;
    logic [NUM_CHAN-1:0][THR_W-1:0] thr;

    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        wire [3:0] blocks = {1'b0, prov_ram_q[c].transfer_size} + 4'h1;
        assign thr[c]        = {blocks, {BLK_SHIFT{1'b0}}};
        assign xfer_req_o[c] = (chan_fill_i[c] >= {4'h0, thr[c]}) | chan_eop_i[c];
        assign req_hi[c]     = xfer_req_o[c] & prov_ram_q[c].prio_en;
        assign req_lo[c]     = xfer_req_o[c] & ~prov_ram_q[c].prio_en;
    end

    logic              pick_valid;
    logic [CHAN_W-1:0] pick_chan;

    // Lowest channel wins within a class; the precedence class overrides
    always_comb begin
        pick_valid = 1'b0;
        pick_chan  = '0;
        for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (req_lo[i]) begin
                pick_valid = 1'b1;
                pick_chan  = CHAN_W'(i);
            end
        end
        for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (req_hi[i]) begin
                pick_valid = 1'b1;
                pick_chan  = CHAN_W'(i);
            end
        end
    end

    logic              svc_valid_q;
    logic [CHAN_W-1:0] svc_chan_q;
    logic [THR_W-1:0]  svc_bytes_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            svc_valid_q <= 1'b0;
            svc_chan_q  <= '0;
            svc_bytes_q <= '0;
        end else begin
            svc_valid_q <= pick_valid;
            svc_chan_q  <= pick_chan;
            svc_bytes_q <= thr[pick_chan];
        end
    end

    assign svc_valid_o = svc_valid_q;
    assign svc_chan_o  = svc_chan_q;
    assign svc_bytes_o = svc_bytes_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial stream conditioning and chain walk
    wire rhbp_prov2_t rx_prov = prov_ram_q[rx_chan_i];
    wire rx_drop = rx_prov.seven_bit_mode & (rx_bit_pos_i == LAST_BIT_POS);

    logic              rx_valid_q;
    logic              rx_bit_q;
    logic [OFS_W-1:0]  rx_offset_q;
    logic [BLK_W-1:0]  walk_next_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_valid_q  <= 1'b0;
            rx_bit_q    <= 1'b0;
            rx_offset_q <= '0;
        end else begin
            rx_valid_q  <= rx_valid_i & ~rx_drop;
            rx_bit_q    <= rx_bit_i ^ rx_prov.invert;
            rx_offset_q <= rx_prov.offset;
        end
    end

    always_ff @(posedge clk_i) begin
        walk_next_q <= blk_ram_q[walk_blk_i];
    end

    assign rx_valid_o  = rx_valid_q;
    assign rx_bit_o    = rx_bit_q;
    assign rx_offset_o = rx_offset_q;
    assign walk_next_o = walk_next_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_blk_busy_len: assert property (blk_start |=> blk_busy [*2] ##1 !blk_busy)
        else $error("block busy not high for exactly the access time");
    a_ch_busy_len: assert property (ch_start |=> ch_busy [*2] ##1 !ch_busy)
        else $error("channel busy not high for exactly the access time");
    a_blk_wr_ram: assert property (blk_done && !blk_dir_q |=> blk_ram_rd == $past(bptr_q))
        else $error("block write did not store pointer");
    a_blk_rd_load: assert property (blk_done && blk_dir_q |=> bptr_q == $past(blk_ram_rd))
        else $error("block read did not load pointer");
    a_ptr_hold: assert property (!blk_done && !(wr_en && hit_bld) |=> $stable(bptr_q))
        else $error("pointer changed without write or read");
    a_ch_rd_load: assert property (ch_done && ch_dir_q |=> data2_q == $past(ch_ram_rd))
        else $error("channel read did not load data word");
    a_xfer_thr: assert property (xfer_req_o[0] == (chan_eop_i[0] ||
        (chan_fill_i[0] >= FILL_W'((prov_ram_q[0].transfer_size + 1) * 16))))
        else $error("transfer request does not match threshold");
    a_prio_first: assert property (|req_hi |=>
        svc_valid_o && |($past(req_hi) & (32'h1 << svc_chan_o)))
        else $error("low class served while precedence request waits");
    a_invert_bit: assert property (rx_valid_i |=>
        rx_bit_o == ($past(rx_bit_i) ^ $past(rx_prov.invert)))
        else $error("stream inversion wrong");
    a_seven_drop: assert property (rx_valid_i && rx_prov.seven_bit_mode &&
        rx_bit_pos_i == LAST_BIT_POS |=> !rx_valid_o)
        else $error("last octet bit not dropped");
    a_offset_out: assert property (rx_valid_i |=> rx_offset_o == $past(rx_prov.offset))
        else $error("packet offset wrong");

    c_blk_write: cover property (blk_start && !req_i.wdata[DIR_BIT] ##3 !blk_busy);
    c_blk_read: cover property (blk_start && req_i.wdata[DIR_BIT] ##3 !blk_busy);
    c_ch_read: cover property (ch_start && req_i.wdata[DIR_BIT] ##3 !ch_busy);
    c_prio_win: cover property (|req_hi && |req_lo);
endmodule : rhbp_core

// file: rhbp_pkg.sv
// Constants, register map and carrier types for the receive channel/block provisioning logic
package rhbp_pkg;

    localparam int NUM_CHAN = 32;
    localparam int CHAN_W   = 5;
    localparam int NUM_BLK  = 512;
    localparam int BLK_W    = 9;
    localparam int FILL_W   = 12;
    localparam int THR_W    = 8;

    // Register offsets
    localparam logic [9:0] OFF_CH_SEL   = 10'h200;
    localparam logic [9:0] OFF_CH_DATA2 = 10'h208;
    localparam logic [9:0] OFF_BLK_SEL  = 10'h210;
    localparam logic [9:0] OFF_BLK_DATA = 10'h214;

    // Field positions
    localparam int BUSY_BIT  = 15;
    localparam int DIR_BIT   = 14;
    localparam int SEVEN_BIT = 15;
    localparam int PRIO_BIT  = 13 + 1;
    localparam int INV_BIT   = 13;
    localparam int OFS_LSB   = 8;
    localparam int OFS_W     = 2;
    localparam int XFER_LSB  = 0;
    localparam int XFER_W    = 3;

    // Transfer size unit is a 16-byte block: threshold = (size + 1) << 4
    localparam int          BLK_SHIFT  = 4;
    localparam logic [2:0]  LAST_BIT_POS = 3'h7;
    // Cycles from select write to completion of an indirect access
    localparam logic [1:0]  ACC_LAT    = 2'h2;

    typedef struct packed {
        logic              seven_bit_mode;
        logic              prio_en;
        logic              invert;
        logic [OFS_W-1:0]  offset;
        logic [XFER_W-1:0] transfer_size;
    } rhbp_prov2_t;

    localparam rhbp_prov2_t PROV2_RST = '0;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  be;
        logic [9:0]  addr;
        logic [31:0] wdata;
    } rhbp_req_t;

    typedef enum logic {ACC_IDLE, ACC_BUSY} rhbp_acc_state_t;

endpackage : rhbp_pkg

// file: test_rhbp_core.sv
// Self-checking testbench for the receive channel/block provisioning logic
`timescale 1ns/10ps
module test_rhbp_core;
    import rhbp_pkg::*;

    logic                            clk_i       = 1'b0;
    logic                            rst_i       = 1'b1;
    rhbp_req_t                       req         = '0;
    logic [31:0]                     rdata_o;
    logic [NUM_CHAN-1:0][FILL_W-1:0] chan_fill_i = '0;
    logic [NUM_CHAN-1:0]             chan_eop_i  = '0;
    logic [NUM_CHAN-1:0]             xfer_req_o;
    logic                            svc_valid_o;
    logic [CHAN_W-1:0]               svc_chan_o;
    logic [THR_W-1:0]                svc_bytes_o;
    logic                            rx_valid_i  = 1'b0;
    logic [CHAN_W-1:0]               rx_chan_i   = '0;
    logic                            rx_bit_i    = 1'b0;
    logic [2:0]                      rx_bit_pos_i = '0;
    logic                            rx_valid_o;
    logic                            rx_bit_o;
    logic [OFS_W-1:0]                rx_offset_o;
    logic [BLK_W-1:0]                walk_blk_i  = '0;
    logic [BLK_W-1:0]                walk_next_o;
    int                              n_mismatch  = 0;
    int                              checked     = 0;

    rhbp_core uut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata_o),
        .chan_fill_i(chan_fill_i), .chan_eop_i(chan_eop_i), .xfer_req_o(xfer_req_o),
        .svc_valid_o(svc_valid_o), .svc_chan_o(svc_chan_o), .svc_bytes_o(svc_bytes_o),
        .rx_valid_i(rx_valid_i), .rx_chan_i(rx_chan_i), .rx_bit_i(rx_bit_i),
        .rx_bit_pos_i(rx_bit_pos_i), .rx_valid_o(rx_valid_o), .rx_bit_o(rx_bit_o),
        .rx_offset_o(rx_offset_o), .walk_blk_i(walk_blk_i), .walk_next_o(walk_next_o));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test;
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // One-cycle strobe, then an idle cycle before the next request
    task automatic bus_wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_i);
        req <= '{wr: 1'b1, rd: 1'b0, be: be, addr: a, wdata: d};
        @(posedge clk_i);
        req <= '0;
    endtask : bus_wr

    task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge clk_i);
        req <= '{wr: 1'b0, rd: 1'b1, be: 4'hf, addr: a, wdata: 32'h0};
        @(posedge clk_i);
        req <= '0;
        #1;
        d = rdata_o;
    endtask : bus_rd

    // Busy must be up right after the select write and drop within a bounded poll
    task automatic wait_idle(input logic [9:0] a);
        logic [31:0] v;
        int          n;
        bus_rd(a, v);
        chk({31'h0, v[BUSY_BIT]}, 32'h1);
        n = 0;
        while (v[BUSY_BIT] === 1'b1 && n < 20) begin
            bus_rd(a, v);
            n++;
        end
        chk({31'h0, v[BUSY_BIT]}, 32'h0);
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        logic [31:0] v;
        bus_rd(OFF_CH_DATA2, v);
        chk(v, 32'h0);
        bus_rd(OFF_BLK_DATA, v);
        chk(v, 32'h0);
        bus_rd(OFF_BLK_SEL, v);
        chk({31'h0, v[BUSY_BIT]}, 32'h0);
        bus_rd(10'h20c, v);
        chk(v, 32'h0);
        bus_wr(OFF_BLK_DATA, 32'h0000_0155, 4'h0);
        bus_rd(OFF_BLK_DATA, v);
        chk(v, 32'h0);
    endtask : t_reset_values

    // Channel 5: seven-bit, precedence, invert, offset 2, size 3
    task automatic t_channel_access;
        logic [31:0] v;
        bus_wr(OFF_CH_DATA2, 32'h0000_e203, 4'hf);
        bus_wr(OFF_CH_SEL, 32'h0000_0005, 4'hf);
        wait_idle(OFF_CH_SEL);
        bus_rd(OFF_CH_SEL, v);
        chk(v & 32'h0000_c01f, 32'h0000_0005);
        bus_wr(OFF_CH_DATA2, 32'h0000_0101, 4'hf);
        bus_rd(OFF_CH_DATA2, v);
        chk(v & 32'h0000_e307, 32'h0000_0101);
        bus_wr(OFF_CH_SEL, 32'h0000_4005, 4'hf);
        wait_idle(OFF_CH_SEL);
        bus_rd(OFF_CH_SEL, v);
        chk(v & 32'h0000_c01f, 32'h0000_4005);
        bus_rd(OFF_CH_DATA2, v);
        chk(v & 32'h0000_e307, 32'h0000_e203);
    endtask : t_channel_access

    task automatic rx_send(input logic [4:0] ch, input logic b, input logic [2:0] pos,
                           input logic ev, input logic eb, input logic [1:0] eo);
        @(posedge clk_i);
        rx_valid_i   <= 1'b1;
        rx_chan_i    <= ch;
        rx_bit_i     <= b;
        rx_bit_pos_i <= pos;
        @(posedge clk_i);
        rx_valid_i   <= 1'b0;
        #1;
        chk({31'h0, rx_valid_o}, {31'h0, ev});
        if (ev) begin
            chk({31'h0, rx_bit_o}, {31'h0, eb});
            chk({30'h0, rx_offset_o}, {30'h0, eo});
        end
    endtask : rx_send

    task automatic t_serial;
        rx_send(5'd5, 1'b1, 3'd0, 1'b1, 1'b0, 2'd2);
        rx_send(5'd5, 1'b0, 3'd6, 1'b1, 1'b1, 2'd2);
        rx_send(5'd5, 1'b1, 3'd7, 1'b0, 1'b0, 2'd2);
        rx_send(5'd2, 1'b1, 3'd7, 1'b1, 1'b1, 2'd0);
    endtask : t_serial

    task automatic set_fill(input logic [4:0] ch, input logic [11:0] f, input logic eop);
        @(posedge clk_i);
        chan_fill_i[ch] <= f;
        chan_eop_i[ch]  <= eop;
        @(posedge clk_i);
        #1;
    endtask : set_fill

    // Channel 5 threshold 64 bytes, channel 2 (size 0) threshold 16 bytes
    task automatic t_service;
        set_fill(5'd5, 12'd63, 1'b0);
        chk({31'h0, xfer_req_o[5]}, 32'h0);
        chk({31'h0, svc_valid_o}, 32'h0);
        set_fill(5'd5, 12'd64, 1'b0);
        chk({31'h0, xfer_req_o[5]}, 32'h1);
        set_fill(5'd2, 12'd15, 1'b0);
        chk({31'h0, xfer_req_o[2]}, 32'h0);
        set_fill(5'd2, 12'd16, 1'b0);
        chk({31'h0, svc_valid_o}, 32'h1);
        chk({27'h0, svc_chan_o}, 32'h5);
        chk({24'h0, svc_bytes_o}, 32'h40);
        set_fill(5'd5, 12'd0, 1'b0);
        chk({27'h0, svc_chan_o}, 32'h2);
        chk({24'h0, svc_bytes_o}, 32'h10);
        set_fill(5'd2, 12'd0, 1'b1);
        chk({31'h0, xfer_req_o[2]}, 32'h1);
        set_fill(5'd2, 12'd0, 1'b0);
        chk({31'h0, svc_valid_o}, 32'h0);
    endtask : t_service

    // Two-entry ring 7 -> 0x1ff -> 7, then read back entry 7
    task automatic t_block_access;
        logic [31:0] v;
        bus_wr(OFF_BLK_DATA, 32'h0000_01ff, 4'hf);
        bus_wr(OFF_BLK_SEL, 32'h0000_0007, 4'hf);
        wait_idle(OFF_BLK_SEL);
        bus_wr(OFF_BLK_DATA, 32'h0000_0007, 4'hf);
        bus_wr(OFF_BLK_SEL, 32'h0000_01ff, 4'hf);
        wait_idle(OFF_BLK_SEL);
        @(posedge clk_i);
        walk_blk_i <= 9'h007;
        @(posedge clk_i);
        walk_blk_i <= 9'h1ff;
        #1;
        chk({23'h0, walk_next_o}, 32'h1ff);
        @(posedge clk_i);
        #1;
        chk({23'h0, walk_next_o}, 32'h007);
        bus_wr(OFF_BLK_DATA, 32'h0000_0055, 4'hf);
        bus_rd(OFF_BLK_DATA, v);
        chk(v & 32'h0000_01ff, 32'h0000_0055);
        bus_wr(OFF_BLK_SEL, 32'h0000_4007, 4'hf);
        wait_idle(OFF_BLK_SEL);
        bus_rd(OFF_BLK_DATA, v);
        chk(v & 32'h0000_01ff, 32'h0000_01ff);
        bus_rd(OFF_BLK_SEL, v);
        chk(v & 32'h0000_c1ff, 32'h0000_4007);
    endtask : t_block_access

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 20000);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_values();
        t_channel_access();
        t_serial();
        t_service();
        t_block_access();
        end_of_test();
    end

endmodule : test_rhbp_core
